// ===== tppwm_pkg.sv
package tppwm_pkg;

    // ------------------------------------------------------------
    // Register bus carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tppwm_bus_s;

    // One phase compare preload or active value; low keeps bits 7:3.
    typedef struct packed {
        logic [7:0] high;
        logic [4:0] low;
    } tppwm_cmp_s;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_REF = 8'h00;
    localparam logic [7:0] OFS_PWM_CTRL = 8'h01;
    localparam logic [7:0] OFS_REP = 8'h02;
    localparam logic [7:0] OFS_W_HIGH = 8'h03;
    localparam logic [7:0] OFS_W_LOW = 8'h04;
    localparam logic [7:0] OFS_V_HIGH = 8'h05;
    localparam logic [7:0] OFS_V_LOW = 8'h06;
    localparam logic [7:0] OFS_U_HIGH = 8'h07;
    localparam logic [7:0] OFS_U_LOW = 8'h08;
    localparam logic [7:0] OFS_PER_HIGH = 8'h09;
    localparam logic [7:0] OFS_PER_LOW = 8'h0a;
    localparam logic [7:0] OFS_CTRL = 8'h0b;
    // Phase index 0 is U, 1 is V, 2 is W.
    localparam logic [7:0] OFS_PH_HIGH [3] = '{OFS_U_HIGH, OFS_V_HIGH,
                                              OFS_W_HIGH};
    localparam logic [7:0] OFS_PH_LOW [3] = '{OFS_U_LOW, OFS_V_LOW,
                                             OFS_W_LOW};

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_REF = 8'h00;
    localparam logic [7:0] RST_PWM_CTRL = 8'h00;
    localparam logic [7:0] RST_REP = 8'h00;
    localparam logic [7:0] RST_CMP_HIGH = 8'h00;
    localparam logic [4:0] RST_CMP_LOW = 5'h00;
    localparam logic [3:0] RST_PER_HIGH = 4'hf;
    localparam logic [7:0] RST_PER_LOW = 8'hff;
    localparam logic [1:0] RST_CTRL = 2'h0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_BEMF = 7;
    localparam int BIT_CURRENT = 6;
    localparam int BIT_CUR_SEL = 5;
    localparam int CHOP_MODE_LSB = 3;
    localparam int CHOP_FREQ_LSB = 0;
    localparam int BIT_WIDTH_MODE = 7;
    localparam int BIT_FULL_U = 6;
    localparam int BIT_ALIGN = 3;
    localparam int PRESCALE_LSB = 0;
    localparam int CMP_LOW_LSB = 3;
    localparam int BIT_CLK_EN = 0;
    localparam int BIT_IRQ_EN = 1;
    localparam int BIT_STARTED = 2;

    // ------------------------------------------------------------
    // Chopper half periods in peripheral clocks (divide 80..4)
    // ------------------------------------------------------------
    localparam int CHOP_HALF_MAX = 40;
    function automatic logic [6:0] chop_half(input logic [2:0] code);
        case (code)
            3'h0: chop_half = 7'h28;
            3'h1: chop_half = 7'h14;
            3'h2: chop_half = 7'h0a;
            3'h3: chop_half = 7'h08;
            3'h4: chop_half = 7'h05;
            3'h5: chop_half = 7'h04;
            3'h6: chop_half = 7'h03;
            default: chop_half = 7'h02;
        endcase
    endfunction

endpackage

// ===== tppwm_chopper.sv
`timescale 1ns/10ps
module tppwm_chopper #(
    parameter int HALF_W = 7
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic enable_i,
    input wire logic [2:0] freq_i,
    // Square wave
    output logic chop_o
);
    import tppwm_pkg::*;

    if ((1 << HALF_W) <= CHOP_HALF_MAX) begin : g_bad_width
        $error("HALF_W too small");
    end

    logic [HALF_W-1:0] half_cnt;
    logic [HALF_W-1:0] half_len;
    wire half_done;

    assign half_len = HALF_W'(chop_half(freq_i));
    assign half_done = (half_cnt >= half_len - HALF_W'(1));

    // Equal high and low halves keep the duty at one half for every code.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            half_cnt <= '0;
            chop_o <= 1'b0;
        end else if (!enable_i) begin
            half_cnt <= '0;
            chop_o <= 1'b0;
        end else if (half_done) begin
            half_cnt <= '0;
            chop_o <= ~chop_o;
        end else begin
            half_cnt <= half_cnt + HALF_W'(1);
        end
    end

endmodule

// ===== tppwm_top.sv
`timescale 1ns/10ps
// Behaviour
// - Reference bit 7 reads the back-EMF hysteresis comparator level.
// - Reference bit 6 reads the current loop comparator level.
// - Bit 5 selects current comparator input: amplifier pin or direct.
// - Chop mode: off, low side only, high side only, both sides.
// - Chop frequency divides the clock by 80,40,20,16,10,8,6 or 4.
// - The chopper wave always has a fifty percent duty cycle.
// - Width mode moves the extension bit to full-duty bits, high byte only.
// - Full-duty bit forces its phase fully on from the next update until the one after.
// - Counter alignment bit: 0 edge aligned, 1 center aligned.
// - Prescale field divides the counter clock by value plus one.
// - Repetition count at zero: transfer compares, signal update, reload.
// - The update interrupt reaches the processor only when enabled.
// - First clock enable after reset loads repetition and raises update.
// - While running, a new repetition value applies after next update.
// - Repetition N updates every N+1 periods or half periods.
// - Phase compare: full high byte plus low bits 7:3; 2:0 reserved.
// - Period high keeps four bits 3:0 and resets to 0f.
// - Reference, control, repetition and phase registers reset to zero.
// - Reading a preloaded register returns its active value.
module tppwm_top (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire tppwm_pkg::tppwm_bus_s bus_i,
    output logic [7:0] rdata_o,
    // Comparator levels from the analog front end
    input wire logic bemf_comparator_level_i,
    input wire logic current_loop_level_i,
    // Towards comparator mux, channel manager and processor
    output logic current_input_select_o,
    output logic [2:0] phase_active_o,
    output logic chop_high_o,
    output logic chop_low_o,
    output logic update_o,
    output logic update_irq_o
);
    import tppwm_pkg::*;

    // ------------------------------------------------------------
    // Comparator synchronisers
    // ------------------------------------------------------------
    logic [1:0] cmp_raw;
    logic [1:0] cmp_lvl;
    assign cmp_raw = {bemf_comparator_level_i, current_loop_level_i};

    for (genvar i = 0; i < 2; i++) begin : g_sync
        logic s1;
        logic s2;
        logic s3;
        // A level counts only once the second and third stages agree.
        always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                s1 <= 1'b0;
                s2 <= 1'b0;
                s3 <= 1'b0;
                cmp_lvl[i] <= 1'b0;
            end else begin
                s1 <= cmp_raw[i];
                s2 <= s1;
                s3 <= s2;
                if (s2 == s3) begin
                    cmp_lvl[i] <= s3;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [5:0] ref_ctrl;
    logic [7:0] pwm_ctrl;
    logic [7:0] rep_pre;
    logic [7:0] rep_act;
    logic [7:0] rep_cnt;
    tppwm_cmp_s cmp_pre [3];
    tppwm_cmp_s cmp_act [3];
    logic [3:0] per_hi_pre;
    logic [3:0] per_hi_act;
    logic [7:0] per_lo_pre;
    logic [7:0] per_lo_act;
    logic [2:0] full_act;
    logic [1:0] ctrl;
    logic started;
    logic upd;
    logic [11:0] cnt;

    wire wr_ref = bus_i.wr && (bus_i.addr == OFS_REF);
    wire wr_pwm = bus_i.wr && (bus_i.addr == OFS_PWM_CTRL);
    wire wr_rep = bus_i.wr && (bus_i.addr == OFS_REP);
    wire wr_per_hi = bus_i.wr && (bus_i.addr == OFS_PER_HIGH);
    wire wr_per_lo = bus_i.wr && (bus_i.addr == OFS_PER_LOW);
    wire wr_ctrl = bus_i.wr && (bus_i.addr == OFS_CTRL);
    wire clk_en = ctrl[BIT_CLK_EN];
    wire width_mode = pwm_ctrl[BIT_WIDTH_MODE];
    wire center = pwm_ctrl[BIT_ALIGN];
    wire [2:0] prescale = pwm_ctrl[PRESCALE_LSB +: 3];
    wire [1:0] chop_mode = ref_ctrl[CHOP_MODE_LSB +: 2];
    wire [2:0] chop_freq = ref_ctrl[CHOP_FREQ_LSB +: 3];
    wire [11:0] period = {per_hi_act, per_lo_act};

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_ctrl <= RST_REF[5:0];
            rep_pre <= RST_REP;
            per_hi_pre <= RST_PER_HIGH;
            per_lo_pre <= RST_PER_LOW;
            ctrl <= RST_CTRL;
        end else begin
            if (wr_ref) begin
                ref_ctrl <= bus_i.wdata[5:0];
            end
            if (wr_rep) begin
                rep_pre <= bus_i.wdata;
            end
            if (wr_per_hi) begin
                per_hi_pre <= bus_i.wdata[3:0];
            end
            if (wr_per_lo) begin
                per_lo_pre <= bus_i.wdata;
            end
            if (wr_ctrl) begin
                ctrl <= bus_i.wdata[1:0];
            end
        end
    end

    // A fresh write of the full-duty bits wins over the hardware clear.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwm_ctrl <= RST_PWM_CTRL;
        end else if (wr_pwm) begin
            pwm_ctrl <= bus_i.wdata;
        end else if (upd) begin
            pwm_ctrl[BIT_FULL_U -: 3] <= 3'h0;
        end
    end

    // ------------------------------------------------------------
    // Phase compare preload and active registers
    // ------------------------------------------------------------
    logic [2:0] phase_on;

    for (genvar p = 0; p < 3; p++) begin : g_phase
        wire wr_hi = bus_i.wr && (bus_i.addr == OFS_PH_HIGH[p]);
        wire wr_lo = bus_i.wr && (bus_i.addr == OFS_PH_LOW[p]);
        wire [11:0] std_val = {cmp_act[p].high[6:0], cmp_act[p].low};
        wire [11:0] wide_val = {cmp_act[p].high, 4'h0};
        wire [11:0] cmp_val = width_mode ? wide_val : std_val;
        wire ext = width_mode ? full_act[p] : cmp_act[p].high[7];

        // The low bits only ever hold the value bits; 2:0 are not stored.
        always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                cmp_pre[p] <= {RST_CMP_HIGH, RST_CMP_LOW};
                cmp_act[p] <= {RST_CMP_HIGH, RST_CMP_LOW};
            end else begin
                if (wr_hi) begin
                    cmp_pre[p].high <= bus_i.wdata;
                end
                if (wr_lo) begin
                    cmp_pre[p].low <= bus_i.wdata[7:CMP_LOW_LSB];
                end
                if (upd) begin
                    cmp_act[p] <= cmp_pre[p];
                end
            end
        end

        assign phase_on[p] = full_act[p] | ext | (cnt < cmp_val);
    end

    // ------------------------------------------------------------
    // Prescaler and PWM counter
    // ------------------------------------------------------------
    logic [2:0] presc_cnt;
    logic down;
    logic [11:0] next_cnt;
    logic next_down;
    logic per_evt;
    wire tick = clk_en && (presc_cnt >= prescale);

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            presc_cnt <= 3'h0;
        end else if (tick || !clk_en) begin
            presc_cnt <= 3'h0;
        end else begin
            presc_cnt <= presc_cnt + 3'h1;
        end
    end

    // Edge mode wraps at the period; center mode turns round at both ends
    // and each turnaround counts as one half period.
    always_comb begin
        next_cnt = cnt;
        next_down = down;
        per_evt = 1'b0;
        if (tick) begin
            if (!center) begin
                next_down = 1'b0;
                if (cnt >= period) begin
                    next_cnt = 12'h000;
                    per_evt = 1'b1;
                end else begin
                    next_cnt = cnt + 12'h001;
                end
            end else if (!down) begin
                if (cnt >= period) begin
                    next_down = 1'b1;
                    next_cnt = period - 12'(period != 12'h000);
                    per_evt = 1'b1;
                end else begin
                    next_cnt = cnt + 12'h001;
                end
            end else begin
                if (cnt == 12'h000) begin
                    next_down = 1'b0;
                    next_cnt = 12'(period != 12'h000);
                    per_evt = 1'b1;
                end else begin
                    next_cnt = cnt - 12'h001;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 12'h000;
            down <= 1'b0;
        end else begin
            cnt <= next_cnt;
            down <= next_down;
        end
    end

    // ------------------------------------------------------------
    // Repetition and update events
    // ------------------------------------------------------------
    wire start_evt = clk_en && !started;
    wire rep_zero_evt = per_evt && (rep_cnt == 8'h00);
    assign upd = start_evt || rep_zero_evt;

    // The active repetition value changes only on an update, so a value
    // written while running waits for the next one.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rep_act <= RST_REP;
            rep_cnt <= RST_REP;
            started <= 1'b0;
            full_act <= 3'h0;
            per_hi_act <= RST_PER_HIGH;
            per_lo_act <= RST_PER_LOW;
        end else begin
            if (start_evt) begin
                started <= 1'b1;
            end
            if (upd) begin
                rep_act <= rep_pre;
                rep_cnt <= rep_pre;
                full_act <= {pwm_ctrl[BIT_FULL_U - 2],
                             pwm_ctrl[BIT_FULL_U - 1],
                             pwm_ctrl[BIT_FULL_U]};
                per_hi_act <= per_hi_pre;
                per_lo_act <= per_lo_pre;
            end else if (per_evt) begin
                rep_cnt <= rep_cnt - 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Chopper
    // ------------------------------------------------------------
    logic chop;

    tppwm_chopper #(
        .HALF_W(7)
    ) u_chopper (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .enable_i(clk_en && (chop_mode != 2'h0)),
        .freq_i(chop_freq),
        .chop_o(chop)
    );

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        case (bus_i.addr)
            OFS_REF: begin
                next_rdata = {cmp_lvl, ref_ctrl};
            end
            OFS_PWM_CTRL: next_rdata = pwm_ctrl;
            OFS_REP: next_rdata = rep_act;
            OFS_W_HIGH: next_rdata = cmp_act[2].high;
            OFS_W_LOW: next_rdata = {cmp_act[2].low, 3'h0};
            OFS_V_HIGH: next_rdata = cmp_act[1].high;
            OFS_V_LOW: next_rdata = {cmp_act[1].low, 3'h0};
            OFS_U_HIGH: next_rdata = cmp_act[0].high;
            OFS_U_LOW: next_rdata = {cmp_act[0].low, 3'h0};
            OFS_PER_HIGH: next_rdata = {4'h0, per_hi_act};
            OFS_PER_LOW: next_rdata = per_lo_act;
            OFS_CTRL: next_rdata = {5'h00, started, ctrl};
            default: next_rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
            current_input_select_o <= 1'b0;
            phase_active_o <= 3'h0;
            chop_high_o <= 1'b0;
            chop_low_o <= 1'b0;
            update_o <= 1'b0;
            update_irq_o <= 1'b0;
        end else begin
            rdata_o <= bus_i.rd ? next_rdata : 8'h00;
            current_input_select_o <= ref_ctrl[BIT_CUR_SEL];
            phase_active_o <= clk_en ? phase_on : 3'h0;
            chop_high_o <= chop && chop_mode[1];
            chop_low_o <= chop && chop_mode[0];
            update_o <= upd;
            update_irq_o <= upd && ctrl[BIT_IRQ_EN];
        end
    end

endmodule

// ===== tppwm_props.sv
`timescale 1ns/10ps
module tppwm_props (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire tppwm_pkg::tppwm_bus_s bus_i,
    input wire logic [7:0] rdata_o,
    // Comparator levels
    input wire logic bemf_comparator_level_i,
    input wire logic current_loop_level_i,
    // Generator outputs
    input wire logic current_input_select_o,
    input wire logic [2:0] phase_active_o,
    input wire logic chop_high_o,
    input wire logic chop_low_o,
    input wire logic update_o,
    input wire logic update_irq_o
);
    import tppwm_pkg::*;
    logic [3:0] bemf_h;
    logic [3:0] cur_h;
    logic [1:0] mode_q;
    logic en_q;
    logic irq_q;
    logic seen_en;
    wire ref_wr = bus_i.wr && bus_i.addr == OFS_REF;
    wire ref_rd = bus_i.rd && bus_i.addr == OFS_REF;
    wire ctrl_wr = bus_i.wr && bus_i.addr == OFS_CTRL;
    // Async inputs: only settled levels count.
    wire bemf_st = bemf_h == 4'hf || bemf_h == 4'h0;
    wire cur_st = cur_h == 4'hf || cur_h == 4'h0;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bemf_h <= 4'h0;
            cur_h <= 4'h0;
            mode_q <= 2'h0;
            {en_q, irq_q, seen_en} <= 3'h0;
        end else begin
            bemf_h <= {bemf_h[2:0], bemf_comparator_level_i};
            cur_h <= {cur_h[2:0], current_loop_level_i};
            if (ref_wr)
                mode_q <= bus_i.wdata[4:3];
            if (ctrl_wr)
                {irq_q, en_q} <= bus_i.wdata[1:0];
            if (ctrl_wr && bus_i.wdata[0])
                seen_en <= 1'b1;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence idle3;
        !en_q && !$past(en_q) && !$past(en_q, 2);
    endsequence

    AST_REF_BEMF: assert property (
        ref_rd && bemf_st |=> rdata_o[BIT_BEMF] == $past(bemf_h[0]))
        else $error("back-emf bit wrong");
    AST_REF_CUR: assert property (
        ref_rd && cur_st |=> rdata_o[BIT_CURRENT] == $past(cur_h[0]))
        else $error("current bit wrong");
    AST_CUR_SEL: assert property (
        ref_wr |-> ##2
        current_input_select_o == $past(bus_i.wdata[BIT_CUR_SEL], 2))
        else $error("input select wrong");
    AST_CHOP_HIGH: assert property (
        chop_high_o |-> mode_q[1] || $past(mode_q[1]) ||
        $past(mode_q[1], 2))
        else $error("high side chopped in wrong mode");
    AST_CHOP_LOW: assert property (
        chop_low_o |-> mode_q[0] || $past(mode_q[0]) ||
        $past(mode_q[0], 2))
        else $error("low side chopped in wrong mode");
    AST_FIRST_EN: assert property (
        ctrl_wr && bus_i.wdata[BIT_CLK_EN] && !seen_en |-> ##2 update_o)
        else $error("first enable gave no update");
    AST_IRQ_GATE: assert property (
        update_irq_o |-> update_o)
        else $error("interrupt without update");
    AST_IRQ_PASS: assert property (
        update_o && irq_q && $past(irq_q) |-> update_irq_o)
        else $error("enabled interrupt missing");
    AST_UPD_PULSE: assert property (
        update_o |=> !update_o)
        else $error("update longer than one cycle");
    AST_IDLE: assert property (
        idle3 |-> !update_o && phase_active_o == 3'h0)
        else $error("activity while counter stopped");

    cover property (update_irq_o);
    cover property (chop_high_o && chop_low_o);
    cover property (phase_active_o == 3'h7);
endmodule

// ===== tppwm_stage.sv
`timescale 1ns/10ps
module tppwm_stage (
    // Levels commanded by the bench
    input wire logic bemf_set_i,
    input wire logic amp_lvl_i,
    input wire logic direct_lvl_i,
    // From the generator
    input wire logic current_input_select_i,
    input wire logic [2:0] phase_active_i,
    input wire logic chop_high_i,
    input wire logic chop_low_i,
    // Comparator levels and switch drive
    output logic bemf_comparator_level_o,
    output logic current_loop_level_o,
    output logic [5:0] switch_o
);
    // The current comparator sees only the routed input.
    assign current_loop_level_o = current_input_select_i ?
        direct_lvl_i : amp_lvl_i;
    assign bemf_comparator_level_o = bemf_set_i;
    // Chopper pulses cut each switch's on-time; low side is the complement.
    assign switch_o = {phase_active_i & ~{3{chop_high_i}},
        ~phase_active_i & ~{3{chop_low_i}}};
endmodule

// ===== testbench.sv
`timescale 1ns/10ps
module testbench;
    import tppwm_pkg::*;
    logic sys_clk_i;
    logic rst_n_i;
    tppwm_bus_s bus;
    logic [7:0] rdata;
    logic bemf, cur, sel, upd, irq, chh, chl;
    logic [2:0] ph;
    logic bemf_set, amp_lvl, dir_lvl;
    int err_count;
    int cmp_count;
    int cyc;
    logic [15:0] e0, n, hi, lo;
    logic [15:0] half [8] = '{40, 20, 10, 8, 5, 4, 3, 2};
    logic [7:0] rst_tab [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h0f, 8'hff, 8'h00};
    wire [4:0] obs = {chl, chh, ph};

    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    tppwm_top i_dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus_i(bus),
        .rdata_o(rdata), .bemf_comparator_level_i(bemf),
        .current_loop_level_i(cur), .current_input_select_o(sel),
        .phase_active_o(ph), .chop_high_o(chh), .chop_low_o(chl),
        .update_o(upd), .update_irq_o(irq));
    tppwm_stage i_stage (
        .bemf_set_i(bemf_set), .amp_lvl_i(amp_lvl),
        .direct_lvl_i(dir_lvl), .current_input_select_i(sel),
        .phase_active_i(ph), .chop_high_i(chh), .chop_low_i(chl),
        .bemf_comparator_level_o(bemf), .current_loop_level_o(cur),
        .switch_o());

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] s, e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, d);
        @(posedge sys_clk_i);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge sys_clk_i);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, e, input string nm);
        @(posedge sys_clk_i);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge sys_clk_i);
        bus.rd <= 1'b0;
        @(negedge sys_clk_i);
        chk(nm, {8'h00, rdata}, {8'h00, e});
    endtask

    // Cycles from the call until the next update.
    task automatic wait_upd(output logic [15:0] c);
        c = 16'd0;
        do begin
            @(negedge sys_clk_i);
            c++;
        end while (upd !== 1'b1 && c < 16'd3000);
    endtask

    task automatic run_len(input int k, output logic [15:0] h, l);
        h = 16'd0;
        l = 16'd0;
        for (int i = 0; i < 300 && obs[k] !== 1'b0; i++)
            @(negedge sys_clk_i);
        for (int i = 0; i < 300 && obs[k] !== 1'b1; i++)
            @(negedge sys_clk_i);
        while (obs[k] === 1'b1 && h < 16'd300) begin
            @(negedge sys_clk_i);
            h++;
        end
        while (obs[k] === 1'b0 && l < 16'd300) begin
            @(negedge sys_clk_i);
            l++;
        end
    endtask

    task automatic cnt_hi(input int k, m, output logic [15:0] h);
        h = 16'd0;
        repeat (m) begin
            @(negedge sys_clk_i);
            h = h + 16'(obs[k]);
        end
    endtask

    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        rst_n_i = 1'b0;
        bus = '0;
        {bemf_set, amp_lvl, dir_lvl} = 3'h0;
        repeat (8) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 12; i++)
            rd(8'(i), rst_tab[i], "reset value");
        rd(8'h20, 8'h00, "unmapped");
        // High byte first, then low byte.
        wr(OFS_PER_HIGH, 8'hf0);
        wr(OFS_PER_LOW, 8'h07);
        wr(OFS_U_HIGH, 8'h00);
        wr(OFS_U_LOW, 8'h1f);
        wr(OFS_W_HIGH, 8'h80);
        wr(OFS_W_LOW, 8'h00);
        rd(OFS_U_LOW, 8'h00, "active before update");
        wr(OFS_CTRL, 8'h03);
        @(negedge sys_clk_i);
        chk("early update", upd, 1'b0);
        @(negedge sys_clk_i);
        chk("first update", {upd, irq}, 2'h3);
        rd(OFS_CTRL, 8'h07, "control");
        rd(OFS_U_LOW, 8'h18, "compare low");
        rd(OFS_PER_HIGH, 8'h00, "period high");
        rd(OFS_PER_LOW, 8'h07, "period low");
        run_len(0, hi, lo);
        chk("U on time", hi, 16'd3);
        cnt_hi(1, 20, n);
        chk("V on time", n, 16'd0);
        cnt_hi(2, 20, n);
        chk("W extension", n, 16'd20);
        wr(OFS_PWM_CTRL, 8'h01);
        run_len(0, hi, lo);
        chk("U prescaled", hi, 16'd6);
        wr(OFS_PWM_CTRL, 8'h00);
        wait_upd(n);
        wait_upd(e0);
        chk("edge period", e0, 16'd8);
        wr(OFS_CTRL, 8'h01);
        wr(OFS_REP, 8'h02);
        rd(OFS_REP, 8'h00, "rep before update");
        wait_upd(n);
        chk("irq off", irq, 1'b0);
        rd(OFS_REP, 8'h02, "rep after update");
        wait_upd(n);
        wait_upd(n);
        chk("edge interval", n, 16'd3 * e0);
        wr(OFS_PWM_CTRL, 8'h08);
        wait_upd(n);
        wait_upd(n);
        wait_upd(hi);
        wr(OFS_REP, 8'h00);
        wait_upd(n);
        wait_upd(n);
        wait_upd(lo);
        chk("center interval", hi, 16'd3 * lo);
        run_len(0, n, lo);
        chk("center U run", n > 16'd4, 1'b1);
        wait_upd(n);
        wr(OFS_PWM_CTRL, 8'h20);
        wait_upd(n);
        repeat (2) @(negedge sys_clk_i);
        cnt_hi(1, e0 - 3, n);
        chk("V full duty", n, e0 - 16'd3);
        rd(OFS_PWM_CTRL, 8'h00, "full duty cleared");
        wait_upd(n);
        wait_upd(n);
        repeat (2) @(negedge sys_clk_i);
        cnt_hi(1, e0 - 3, n);
        chk("V after full duty", n, 16'd0);
        wr(OFS_PWM_CTRL, 8'h80);
        repeat (3) @(negedge sys_clk_i);
        cnt_hi(0, 20, n);
        chk("U width mode", n, 16'd0);
        wr(OFS_PWM_CTRL, 8'h00);
        @(posedge sys_clk_i);
        bemf_set <= 1'b1;
        amp_lvl <= 1'b1;
        wr(OFS_REF, 8'h00);
        repeat (4) @(posedge sys_clk_i);
        rd(OFS_REF, 8'hc0, "comparator bits");
        wr(OFS_REF, 8'h20);
        repeat (4) @(posedge sys_clk_i);
        chk("input select", sel, 1'b1);
        rd(OFS_REF, 8'ha0, "direct input");
        for (int c = 0; c < 8; c++) begin
            wr(OFS_REF, 8'h08 | 8'(c));
            run_len(4, hi, lo);
            chk("chop high time", hi, half[c]);
            chk("chop low time", lo, half[c]);
        end
        for (int m = 0; m < 4; m++) begin
            wr(OFS_REF, 8'(m << 3) | 8'h07);
            repeat (8) @(negedge sys_clk_i);
            cnt_hi(3, 8, hi);
            cnt_hi(4, 8, lo);
            chk("chop high side", hi, m[1] ? 16'd4 : 16'd0);
            chk("chop low side", lo, m[0] ? 16'd4 : 16'd0);
        end
        close_out();
    end
endmodule

bind tppwm_top tppwm_props i_props (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .bemf_comparator_level_i(bemf_comparator_level_i),
    .current_loop_level_i(current_loop_level_i),
    .current_input_select_o(current_input_select_o),
    .phase_active_o(phase_active_o), .chop_high_o(chop_high_o),
    .chop_low_o(chop_low_o), .update_o(update_o),
    .update_irq_o(update_irq_o));
